// ---- verilog/csrx_top.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "csrx_regs.svh"
module csrx_top import csrx_pkg::*; #(
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // interrupt
  output logic               irq,
  // externally mapped quadlets
  output logic [31:0]        rom_quadlet,
  output logic [31:0]        bus_name_quadlet,
  // serial eeprom
  input  wire logic          ee_present,
  input  wire logic          ee_data,
  output logic               ee_clk
);
  if (DW != 32) begin : g_bad_dw
    $error("csrx_top: only 32-bit data is supported");
  end

  // ********************************
  // decode
  // ********************************
  function automatic logic hit_at(input logic [31:0] a, input logic [11:0] ofs);
    hit_at = (a[31:`CSRX_ADDR_W] == '0) && (a[`CSRX_ADDR_W-1:0] == ofs);
  endfunction : hit_at

  logic        setup, access;
  logic        h_data, h_cmp, h_ctrl, h_rom, h_bus, h_stat, h_mask, h_any;
  logic        wr, rd;
  logic        wr_data, wr_cmp, wr_ctrl, wr_rom, wr_mask, rd_stat;
  logic [31:0] rdata;

  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign h_data  = hit_at(paddr, `CSRX_OFS_DATA);
  assign h_cmp   = hit_at(paddr, `CSRX_OFS_CMP);
  assign h_ctrl  = hit_at(paddr, `CSRX_OFS_CTRL);
  assign h_rom   = hit_at(paddr, `CSRX_OFS_ROM);
  assign h_bus   = hit_at(paddr, `CSRX_OFS_BUSNAME);
  assign h_stat  = hit_at(paddr, `CSRX_OFS_STAT);
  assign h_mask  = hit_at(paddr, `CSRX_OFS_MASK);
  assign h_any   = h_data | h_cmp | h_ctrl | h_rom | h_bus | h_stat | h_mask;
  assign wr      = access && pwrite && h_any;
  assign rd      = access && !pwrite && h_any;
  assign wr_data = wr && h_data;
  assign wr_cmp  = wr && h_cmp;
  assign wr_ctrl = wr && h_ctrl;
  assign wr_rom  = wr && h_rom;
  assign wr_mask = wr && h_mask;
  assign rd_stat = rd && h_stat;

  // ********************************
  // registers
  // ********************************
  logic [31:0]            swap_q, cmp_q, rom_q;
  logic [1:0]             sel_q;
  logic                   done_q, done_d;
  logic [`CSRX_IRQ_W-1:0] stat_q, stat_d, mask_q, ev;
  logic [`CSRX_IRQ_W-1:0] stat_clr, mask_d;
  logic                   sw_busy, sw_done, ld_pulse;
  logic [31:0]            sw_old;
  logic [`CSRX_CRC_W-1:0] ld_val;
  logic [31:0]            rom_d;

  // a finishing swap wins over a clearing write in the same cycle
  assign done_d = sw_done ? 1'b1 : (wr_ctrl ? 1'b0 : done_q);
  assign ev     = {ld_pulse, sw_done};
  // a read clears only the bits it reported, so an event landing between
  // the setup edge and the access edge is kept for the next read
  assign stat_clr = rd_stat ? prdata[`CSRX_IRQ_W-1:0] : '0;
  assign stat_d   = ev | (stat_q & ~stat_clr);
  assign mask_d   = wr_mask ? pwdata[`CSRX_IRQ_W-1:0] : mask_q;
  assign rom_d  = {wr_rom ? pwdata[`CSRX_INFO_HI:`CSRX_CRCLEN_LO] : rom_q[31:16],
                   ld_pulse ? ld_val : (wr_rom ? pwdata[`CSRX_CRC_HI:0] : rom_q[15:0])};

  assign rdata = h_data ? swap_q :
                 h_cmp  ? cmp_q  :
                 h_ctrl ? {done_q, 29'h0000_0000, sel_q} :
                 h_rom  ? rom_q  :
                 h_bus  ? `CSRX_BUS_NAME :
                 h_stat ? 32'(stat_q) :
                 h_mask ? 32'(mask_q) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_q <= 32'h0000_0000;
      cmp_q  <= 32'h0000_0000;
      sel_q  <= 2'h0;
      mask_q <= '0;
    end else begin
      if (wr_data) swap_q <= pwdata;
      else if (sw_done) swap_q <= sw_old;
      if (wr_cmp) cmp_q <= pwdata;
      if (wr_ctrl) sel_q <= pwdata[`CSRX_SEL_HI:`CSRX_SEL_LO];
      if (wr_mask) mask_q <= pwdata[`CSRX_IRQ_W-1:0];
    end
  end

  // done resets to one: no swap is outstanding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b1;
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      done_q <= done_d;
      stat_q <= stat_d;
      irq    <= |(stat_d & mask_d);
    end
  end

  // crc value reset is zero here; the field is undefined without an eeprom
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_q            <= `CSRX_ROM_RST;
      rom_quadlet      <= `CSRX_ROM_RST;
      bus_name_quadlet <= `CSRX_BUS_NAME;
    end else begin
      rom_q            <= rom_d;
      rom_quadlet      <= rom_d;
      bus_name_quadlet <= `CSRX_BUS_NAME;
    end
  end

  // ********************************
  // apb answer, no wait state
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !h_any;
      prdata  <= (setup && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ********************************
  // compare-swap and eeprom
  // ********************************
  csrx_swap_engine #(.DW(32)) u_swap (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (wr_ctrl),
    .sel       (pwdata[`CSRX_SEL_HI:`CSRX_SEL_LO]),
    .swap_data (swap_q),
    .cmp_data  (cmp_q),
    .busy      (sw_busy),
    .done      (sw_done),
    .old_value (sw_old)
  );

  csrx_eeprom_load #(.BITS(`CSRX_CRC_W)) u_load (
    .pclk       (pclk),
    .presetn    (presetn),
    .ee_present (ee_present),
    .ee_data    (ee_data),
    .ee_clk     (ee_clk),
    .load       (ld_pulse),
    .value      (ld_val)
  );

  // ********************************
  // checks
  // ********************************
  a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
    sw_done |=> done_q)
    else $error("done flag not set after swap completion");

  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !sw_done) |=> !done_q)
    else $error("done flag not cleared by control write");

  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && h_ctrl) |-> prdata[30:2] == 29'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_sel_stored: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> sel_q == $past(pwdata[1:0]))
    else $error("resource select not stored");

  a_swap_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !sw_busy && !sw_done) |=> !done_q ##1 !done_q ##1 done_q)
    else $error("swap did not complete in time");

  a_crc_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    ld_pulse |=> rom_q[15:0] == $past(ld_val))
    else $error("crc value not loaded from eeprom");

  a_len_by_write: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(rom_q[31:16]) |-> $past(wr_rom))
    else $error("length fields changed without a write");

  a_rom_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    rom_quadlet == rom_q)
    else $error("external rom quadlet differs from header register");

  a_bus_name: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && h_bus) |-> prdata == `CSRX_BUS_NAME)
    else $error("bus name register read wrong value");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(stat_q & mask_q))
    else $error("interrupt output does not match status and mask");
endmodule : csrx_top

// ---- verilog/csrx_regs.svh ----
`ifndef CSRX_REGS_SVH
`define CSRX_REGS_SVH
// ********************************
// register offsets
// ********************************
`define CSRX_ADDR_W        12
`define CSRX_OFS_DATA      12'h00C
`define CSRX_OFS_CMP       12'h010
`define CSRX_OFS_CTRL      12'h014
`define CSRX_OFS_ROM       12'h018
`define CSRX_OFS_BUSNAME   12'h01C
`define CSRX_OFS_STAT      12'h030
`define CSRX_OFS_MASK      12'h034
// ********************************
// fields and reset values
// ********************************
`define CSRX_DONE_BIT      31
`define CSRX_SEL_HI        1
`define CSRX_SEL_LO        0
`define CSRX_INFO_HI       31
`define CSRX_CRCLEN_LO     16
`define CSRX_CRC_HI        15
`define CSRX_CRC_W         16
`define CSRX_BUS_NAME      32'h3133_3934
`define CSRX_ROM_RST       32'h0000_0000
`define CSRX_RES0_RST      32'h0000_003F
`define CSRX_RES1_RST      32'h0000_1333
`define CSRX_RES2_RST      32'hFFFF_FFFF
`define CSRX_RES3_RST      32'hFFFF_FFFF
`define CSRX_IRQ_SWAP      0
`define CSRX_IRQ_LOAD      1
`define CSRX_IRQ_W         2
// ********************************
// timing
// ********************************
`define CSRX_CLK_NS        10
`define CSRX_EE_HALF_NS    5000
`define CSRX_SYNC_WAIT     2
`endif

// ---- verilog/csrx_pkg.sv ----
package csrx_pkg;
  typedef enum logic [1:0] {
    RES_BUS_MANAGER_ID,
    RES_BANDWIDTH_AVAILABLE,
    RES_CHANNELS_AVAILABLE_HI,
    RES_CHANNELS_AVAILABLE_LO
  } csrx_res_e;
  typedef enum logic [1:0] {SW_IDLE, SW_CMP} csrx_swap_e;
  typedef enum logic [1:0] {LD_WAIT, LD_SHIFT, LD_DONE} csrx_load_e;
endpackage : csrx_pkg

// ---- verilog/csrx_swap_engine.sv ----
`timescale 1ns/1ps
`include "csrx_regs.svh"
module csrx_swap_engine import csrx_pkg::*; #(
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // request
  input  wire logic          start,
  input  wire logic [1:0]    sel,
  input  wire logic [DW-1:0] swap_data,
  input  wire logic [DW-1:0] cmp_data,
  // answer
  output logic               busy,
  output logic               done,
  output logic [DW-1:0]      old_value
);
  if (DW < 1) begin : g_bad_dw
    $error("csrx_swap_engine: DW must be positive");
  end

  localparam logic [31:0] RST_VAL [4] = '{`CSRX_RES0_RST, `CSRX_RES1_RST,
                                          `CSRX_RES2_RST, `CSRX_RES3_RST};
  csrx_swap_e    st_q;
  logic [1:0]    sel_q;
  logic [DW-1:0] res_q [4];
  logic [DW-1:0] cur;
  logic          hit;

  assign cur  = res_q[sel_q];
  assign hit  = (st_q == SW_CMP) && (cur == cmp_data);
  assign busy = (st_q != SW_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= SW_IDLE;
      sel_q     <= 2'h0;
      done      <= 1'b0;
      old_value <= '0;
    end else begin
      done <= 1'b0;
      case (st_q)
        SW_IDLE: if (start) begin
          sel_q <= sel;
          st_q  <= SW_CMP;
        end
        SW_CMP: begin
          old_value <= cur;
          done      <= 1'b1;
          st_q      <= SW_IDLE;
        end
        default: st_q <= SW_IDLE;
      endcase
    end
  end

  // ********************************
  // bus-management resources
  // ********************************
  for (genvar i = 0; i < 4; i++) begin : g_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) res_q[i] <= DW'(RST_VAL[i]);
      else if (hit && (sel_q == 2'(i))) res_q[i] <= swap_data;
    end
  end

  a_swap_on_hit: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> res_q[sel_q] == $past(swap_data))
    else $error("swap data not stored after a matching compare");
  a_swap_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == SW_CMP && !hit) |=> $stable(res_q[sel_q]))
    else $error("resource changed after a failed compare");
endmodule : csrx_swap_engine

// ---- verilog/csrx_eeprom_load.sv ----
`timescale 1ns/1ps
`include "csrx_regs.svh"
module csrx_eeprom_load import csrx_pkg::*; #(
  parameter int BITS     = `CSRX_CRC_W,
  parameter int HALF_CYC = `CSRX_EE_HALF_NS / `CSRX_CLK_NS
) (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // serial eeprom pins
  input  wire logic            ee_present,
  input  wire logic            ee_data,
  output logic                 ee_clk,
  // loaded value
  output logic                 load,
  output logic [BITS-1:0]      value
);
  // the shifter needs two bits at least and the divider is sixteen bits wide
  if (BITS < 2 || HALF_CYC < 1 || HALF_CYC > 65536) begin : g_bad_param
    $error("csrx_eeprom_load: bad parameters");
  end

  csrx_load_e          st_q;
  logic [1:0]          pres_s, dat_s;
  logic [15:0]         div_q;
  logic [$clog2(BITS+1)-1:0] cnt_q;
  logic [1:0]          wait_q;
  logic                tick;

  // two-flop synchronisers; logic reads only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_s <= 2'h0;
      dat_s  <= 2'h0;
    end else begin
      pres_s <= {pres_s[0], ee_present};
      dat_s  <= {dat_s[0], ee_data};
    end
  end

  assign tick = (div_q == 16'(HALF_CYC - 1));

  // strap is caught after release, once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= LD_WAIT;
      div_q  <= 16'h0;
      cnt_q  <= '0;
      wait_q <= 2'h0;
      ee_clk <= 1'b0;
      load   <= 1'b0;
      value  <= '0;
    end else begin
      load <= 1'b0;
      case (st_q)
        LD_WAIT: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == 2'(`CSRX_SYNC_WAIT)) st_q <= pres_s[1] ? LD_SHIFT : LD_DONE;
        end
        LD_SHIFT: begin
          div_q <= tick ? 16'h0 : div_q + 16'h1;
          if (tick) begin
            ee_clk <= ~ee_clk;
            // data sampled on the falling edge, long after it settled
            if (ee_clk) begin
              value <= {value[BITS-2:0], dat_s[1]};
              cnt_q <= cnt_q + 1'b1;
              if (cnt_q == $bits(cnt_q)'(BITS - 1)) begin
                load <= 1'b1;
                st_q <= LD_DONE;
              end
            end
          end
        end
        default: st_q <= LD_DONE;
      endcase
    end
  end
endmodule : csrx_eeprom_load

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "csrx_regs.svh"
module testbench import csrx_pkg::*; ;
  // ********************************
  // signals
  // ********************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic [31:0] rom_quadlet;
  logic [31:0] bus_name_quadlet;
  logic        ee_present;
  logic        ee_data;
  logic        ee_clk;
  logic        ee_clk_d;
  int          nfall;
  bit          chained;
  int          error_cnt;
  int          tests_run;
  localparam logic [15:0] EE_PAT = 16'hA5C3;
  localparam logic [31:0] A_DATA = {20'h0_0000, `CSRX_OFS_DATA};
  localparam logic [31:0] A_CMP  = {20'h0_0000, `CSRX_OFS_CMP};
  localparam logic [31:0] A_CTRL = {20'h0_0000, `CSRX_OFS_CTRL};
  localparam logic [31:0] A_ROM  = {20'h0_0000, `CSRX_OFS_ROM};
  localparam logic [31:0] A_BUS  = {20'h0_0000, `CSRX_OFS_BUSNAME};
  localparam logic [31:0] A_STAT = {20'h0_0000, `CSRX_OFS_STAT};
  localparam logic [31:0] A_MASK = {20'h0_0000, `CSRX_OFS_MASK};
  logic [31:0] rst_v [4] = '{`CSRX_RES0_RST, `CSRX_RES1_RST, `CSRX_RES2_RST, `CSRX_RES3_RST};

  csrx_top u_csrx_top (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pready           (pready),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .irq              (irq),
    .rom_quadlet      (rom_quadlet),
    .bus_name_quadlet (bus_name_quadlet),
    .ee_present       (ee_present),
    .ee_data          (ee_data),
    .ee_clk           (ee_clk)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ********************************
  // serial eeprom stand-in
  // ********************************
  // data changes on the rising serial clock so it is settled long before the sampling fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_clk_d <= 1'b0;
      nfall    <= 0;
      ee_data  <= EE_PAT[15];
    end else begin
      ee_clk_d <= ee_clk;
      if (ee_clk && !ee_clk_d && nfall < 16) begin
        ee_data <= EE_PAT[15 - nfall];
      end
      if (!ee_clk && ee_clk_d) begin
        nfall <= nfall + 1;
      end
    end
  end

  // ********************************
  // apb master and checks
  // ********************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // hold keeps psel up so the next setup follows the access at once
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input bit hold,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    if (!chained) @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t no pready", $time);
      final_report();
    end
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
    if (!hold) psel <= 1'b0;
    chained = hold;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input bit hold);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, hold, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, 1'b0, r, e);
    chk(r, exp, m);
    chk({31'h0, e}, 32'h0000_0000, "pslverr on mapped");
  endtask : rd

  task automatic poll(input logic [31:0] a, input int b, input int bound, output logic [31:0] r);
    logic e;
    int   n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000, 1'b0, r, e);
      n++;
    end while (r[b] !== 1'b1 && n < bound);
    if (r[b] !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t poll bound used up", $time);
      final_report();
    end
  endtask : poll

  task automatic do_swap(input logic [1:0] s, input logic [31:0] d, input logic [31:0] c,
                         input logic [31:0] old, input logic exp_irq);
    logic [31:0] r;
    wr(A_DATA, d, 1'b0);
    wr(A_CMP, c, 1'b0);
    wr(A_CTRL, {1'b1, 29'h1FFF_FFFF, s}, 1'b1);
    rd(A_CTRL, {30'h0, s}, "done not cleared by write");
    poll(A_CTRL, 31, 20, r);
    chk(r, {1'b1, 29'h0, s}, "control after swap");
    rd(A_DATA, old, "old resource value");
    chk({31'h0, irq}, {31'h0, exp_irq}, "irq after swap");
    rd(A_STAT, 32'h0000_0001, "status after swap");
    rd(A_CTRL, {1'b1, 29'h0, s}, "done stands");
    chk({31'h0, irq}, 32'h0000_0000, "irq after status read");
  endtask : do_swap

  // ********************************
  // tests
  // ********************************
  initial begin
    logic [31:0] r;
    logic        e;
    logic [31:0] nv;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 32'h0000_0000;
    pwdata     = 32'h0000_0000;
    ee_present = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, 32'h8000_0000, "control reset");
    rd(A_ROM, `CSRX_ROM_RST, "header reset");
    rd(A_BUS, `CSRX_BUS_NAME, "bus name");
    chk(bus_name_quadlet, `CSRX_BUS_NAME, "bus name port");
    $display("test reset_values done");
    poll(A_STAT, 1, 8000, r);
    chk({31'h0, r[1]}, 32'h0000_0001, "eeprom load event");
    rd(A_ROM, {16'h0000, EE_PAT}, "crc loaded");
    chk(rom_quadlet, {16'h0000, EE_PAT}, "rom port after load");
    chk({31'h0, ee_clk}, 32'h0000_0000, "serial clock idle after load");
    $display("test eeprom_load done");
    wr(A_ROM, 32'h1234_5678, 1'b0);
    rd(A_ROM, 32'h1234_5678, "header readback");
    chk(rom_quadlet, 32'h1234_5678, "rom port");
    wr(A_BUS, 32'hFFFF_FFFF, 1'b0);
    rd(A_BUS, `CSRX_BUS_NAME, "bus name after write");
    apb(1'b0, 32'h0000_0040, 32'h0000_0000, 1'b0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, 32'h0000_1014, 32'h0000_0000, 1'b0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000, "high address bits");
    $display("test header_and_name done");
    wr(A_MASK, 32'h0000_0001, 1'b0);
    for (int i = 0; i < 4; i++) begin
      nv = 32'h1234_0000 + i;
      do_swap(i[1:0], nv, rst_v[i], rst_v[i], 1'b1);
      do_swap(i[1:0], 32'h0000_0000, rst_v[i], nv, 1'b1);
      do_swap(i[1:0], 32'h0000_0000, nv, nv, 1'b1);
    end
    $display("test swap_all_resources done");
    wr(A_MASK, 32'h0000_0000, 1'b0);
    do_swap(2'b00, 32'h0000_0007, 32'h0000_0000, 32'h0000_0000, 1'b0);
    // second control write lands in the cycle the first swap finishes
    wr(A_CTRL, 32'h0000_0001, 1'b1);
    wr(A_CTRL, 32'h0000_0002, 1'b0);
    poll(A_CTRL, 31, 20, r);
    chk(r, 32'h8000_0002, "back to back control writes");
    $display("test masked_and_back_to_back done");
    // second reset with the strap low: lengths clear and no serial load follows
    presetn    <= 1'b0;
    ee_present <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (1100) @(posedge pclk);
    rd(A_ROM, `CSRX_ROM_RST, "header after second reset");
    rd(A_CTRL, 32'h8000_0000, "control after second reset");
    chk({31'h0, ee_clk}, 32'h0000_0000, "serial clock idle, no strap");
    $display("test second_reset done");
    final_report();
  end
endmodule : testbench
